/* File: logic/itw_top.sv */
// Interrupt controller, three auto-reload timers and key/external wake-up
`timescale 1ns/1ps
`include "itw_defs.svh"

module itw_top
    import itw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] wake_port,
    input wire logic external_event_pin,
    input wire logic sound_engine_maskable_req,
    input wire logic nmi_ack,
    input wire logic irq_ack,
    output logic nmi_out,
    output logic irq_out,
    output logic [3:0] irq_level,
    output logic sleep_out,
    output logic infrared_carrier_pin_o,
    output logic infrared_carrier_pin_oe,
    output logic sample_tick
);

    itw_state_s st;
    itw_state_s next_st;

    // Index of lowest set bit of a 10-bit mask, 10 when empty
    function automatic logic [3:0] itw_lowest(input logic [9:0] m);
        logic [3:0] idx;
        idx = 4'hA;
        for (int i = 9; i >= 0; i--) begin
            if (m[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction : itw_lowest

    function automatic logic itw_is_tmr(input logic [11:0] a,
                                        input logic [11:0] base,
                                        output logic [1:0] n);
        logic hit;
        hit = 1'b0;
        n = 2'd0;
        for (int i = 0; i < `ITW_TMR_COUNT; i++) begin
            if (a == base + 12'(i) * `ITW_TMR_STRIDE) begin
                hit = 1'b1;
                n = 2'(i);
            end
        end
        return hit;
    endfunction : itw_is_tmr

    always_comb begin
        logic acc;
        logic wr;
        logic rd_hit;
        logic [31:0] rdata;
        logic [1:0] tn;
        logic [5:0] nmi_set;
        logic [9:0] irq_set;
        logic [5:0] nmi_clr;
        logic [9:0] irq_clr;
        logic [2:0] ovf;
        logic key_diff;
        logic ext_edge;
        logic [3:0] irq_win;
        logic [3:0] isr_top;
        logic [9:0] irq_live;
        next_st = st;
        acc = psel & penable & st.pready;
        wr = acc & pwrite;
        rd_hit = 1'b1;
        rdata = 32'h0000_0000;
        tn = 2'd0;
        nmi_set = 6'h00;
        irq_set = 10'h000;
        nmi_clr = 6'h00;
        irq_clr = 10'h000;
        ovf = 3'h0;

        // Pins pass two flops; logic reads the second stage, and the edge detect also reads a third flop on the event pin
        next_st.wake_s1 = wake_port;
        next_st.wake_s2 = st.wake_s1;
        next_st.ext_s1 = external_event_pin;
        next_st.ext_s2 = st.ext_s1;
        next_st.ext_d = st.ext_s2;

        key_diff = st.key_en & (st.wake_s2 != st.wake_ref);
        ext_edge = st.ext_rise ? (st.ext_s2 & ~st.ext_d)
                               : (~st.ext_s2 & st.ext_d);

        next_st.div = st.div + 21'd1;

        // Timers, identical and independently selected
        for (int t = 0; t < `ITW_TMR_COUNT; t++) begin
            logic run;
            case (st.tmr[t].sel)
                `ITW_SEL_GATED: run = st.ext_s2;
                `ITW_SEL_FREE: run = 1'b1;
                default: run = 1'b0;
            endcase
            if (run) begin
                if (st.tmr[t].count == `ITW_TMR_MAX) begin
                    next_st.tmr[t].count = st.tmr[t].preload;
                    ovf[t] = 1'b1;
                end else begin
                    next_st.tmr[t].count = st.tmr[t].count + 12'd1;
                end
            end
        end

        // Source mapping for both classes
        nmi_set[`ITW_NMI_TMR0 +: 3] = ovf;
        nmi_set[`ITW_NMI_DIV] = &st.div[`ITW_DIV_SHORT_BITS-1:0];
        nmi_set[`ITW_NMI_KEY] = key_diff;
        nmi_set[`ITW_EXTERNAL_NONMASKABLE_REQ] = ext_edge;
        irq_set[`ITW_IRQ_TMR0 +: 3] = ovf;
        irq_set[`ITW_IRQ_DIV_SHORT] =
            &st.div[`ITW_DIV_SHORT_BITS-1:0];
        irq_set[`ITW_IRQ_DIV_MEDIUM] = &st.div[`ITW_DIV_MEDIUM_BITS-1:0];
        irq_set[`ITW_IRQ_DIV_LONG] = &st.div[`ITW_DIV_LONG_BITS-1:0];
        irq_set[`ITW_IRQ_DIV_LONGEST] = &st.div[`ITW_DIV_LONGEST_BITS-1:0];
        irq_set[`ITW_IRQ_KEY] = key_diff;
        irq_set[`ITW_EXTERNAL_MASKABLE_REQ] = ext_edge;
        irq_set[`ITW_IRQ_SOUND] = sound_engine_maskable_req;

        // Carrier toggles on each first-timer overflow
        if (ovf[0]) begin
            next_st.carrier = ~st.carrier;
        end
        next_st.sample_tick = ovf[0];

        // Register read mux, data captured as pready is raised
        case (paddr)
            `ITW_OFF_CTRL: begin
                rdata[`ITW_CTRL_KEY_EN] = st.key_en;
                rdata[`ITW_CTRL_EXT_RISE] = st.ext_rise;
                rdata[`ITW_CTRL_CARRIER_EN] = st.carrier_en;
                rdata[`ITW_CTRL_SLEEP] = st.sleep;
            end
            `ITW_OFF_WAKE_REF: rdata[7:0] = st.wake_ref;
            `ITW_OFF_NMI_EN: rdata[5:0] = st.nmi_en;
            `ITW_OFF_IRQ_EN: rdata[9:0] = st.irq_en;
            `ITW_OFF_NMI_PEND: rdata[5:0] = st.nmi_pend;
            `ITW_OFF_IRQ_PEND: rdata[9:0] = st.irq_pend;
            `ITW_OFF_SERVICE: rdata[10:0] = {st.nmi_act, st.irq_isr};
            default: begin
                if (itw_is_tmr(paddr, `ITW_OFF_TMR_CFG0, tn)) begin
                    rdata[2:0] = st.tmr[tn].sel;
                end else if (itw_is_tmr(paddr, `ITW_OFF_TMR_DATA0, tn)) begin
                    rdata[27:0] = {st.tmr[tn].preload, 4'h0,
                                   st.tmr[tn].count};
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase

        // One wait state: pready rises in the second access cycle
        next_st.pready = psel & penable & ~st.pready;
        next_st.pslverr = psel & penable & ~st.pready & ~rd_hit;
        if (psel & penable & ~st.pready) begin
            next_st.prdata = rd_hit ? rdata : 32'h0000_0000;
        end

        if (wr) begin
            case (paddr)
                `ITW_OFF_CTRL: begin
                    next_st.key_en = pwdata[`ITW_CTRL_KEY_EN];
                    next_st.ext_rise = pwdata[`ITW_CTRL_EXT_RISE];
                    next_st.carrier_en = pwdata[`ITW_CTRL_CARRIER_EN];
                    if (pwdata[`ITW_CTRL_SLEEP]) begin
                        next_st.sleep = 1'b1;
                    end
                end
                `ITW_OFF_WAKE_REF: next_st.wake_ref = pwdata[7:0];
                `ITW_OFF_NMI_EN: next_st.nmi_en = pwdata[5:0];
                `ITW_OFF_IRQ_EN: next_st.irq_en = pwdata[9:0];
                `ITW_OFF_NMI_PEND: nmi_clr = pwdata[5:0];
                `ITW_OFF_IRQ_PEND: irq_clr = pwdata[9:0];
                `ITW_OFF_SERVICE: begin
                    if (pwdata[`ITW_SVC_END_NMI]) begin
                        next_st.nmi_act = 1'b0;
                    end
                    if (pwdata[`ITW_SVC_END_IRQ] &&
                        itw_lowest(st.irq_isr) != 4'hA) begin
                        next_st.irq_isr[itw_lowest(st.irq_isr)] = 1'b0;
                    end
                end
                default: begin
                    if (itw_is_tmr(paddr, `ITW_OFF_TMR_CFG0, tn)) begin
                        next_st.tmr[tn].sel = pwdata[2:0];
                    end else if (itw_is_tmr(paddr, `ITW_OFF_TMR_DATA0,
                                            tn)) begin
                        next_st.tmr[tn].preload = pwdata[11:0];
                        next_st.tmr[tn].count = pwdata[11:0];
                    end
                end
            endcase
        end

        // Write-one clears; a new event in the same cycle wins
        next_st.nmi_pend = (st.nmi_pend & ~nmi_clr) | nmi_set;
        next_st.irq_pend = (st.irq_pend & ~irq_clr) | irq_set;

        // Acknowledge marks the dispatched level in service
        if (nmi_ack & st.nmi_out) begin
            next_st.nmi_act = 1'b1;
        end
        if (irq_ack & st.irq_out) begin
            next_st.irq_isr[st.irq_level - 4'd1] = 1'b1;
        end

        // Priority: NMIs do not nest; IRQs nest only by higher priority
        irq_live = st.irq_pend & st.irq_en & ~next_st.irq_isr;
        irq_win = itw_lowest(irq_live);
        isr_top = itw_lowest(next_st.irq_isr);
        next_st.nmi_out = |(st.nmi_pend & st.nmi_en) &
                          ~next_st.nmi_act;
        next_st.irq_out = ~next_st.nmi_act & (irq_win < isr_top);
        next_st.irq_level = next_st.irq_out ? irq_win + 4'd1
                                            : `ITW_RST_LEVEL;

        // Carrier rests low while the pin is not enabled, so the pin
        // output can come straight from its flop
        if (!next_st.carrier_en) begin
            next_st.carrier = 1'b0;
        end

        // Wake on any enabled request or key mismatch
        if (st.sleep && (|(st.nmi_pend & st.nmi_en) ||
                         |(st.irq_pend & st.irq_en) || key_diff)) begin
            next_st.sleep = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign nmi_out = st.nmi_out;
    assign irq_out = st.irq_out;
    assign irq_level = st.irq_level;
    assign sleep_out = st.sleep;
    assign infrared_carrier_pin_o = st.carrier;
    assign infrared_carrier_pin_oe = st.carrier_en;
    assign sample_tick = st.sample_tick;

endmodule : itw_top

/* File: common/itw_defs.svh */
// Register offsets, field positions, reset values and counts of the interrupt/timer block
`ifndef ITW_DEFS_SVH
`define ITW_DEFS_SVH

`define ITW_OFF_CTRL 12'h000
`define ITW_OFF_WAKE_REF 12'h004
`define ITW_OFF_NMI_EN 12'h008
`define ITW_OFF_IRQ_EN 12'h00C
`define ITW_OFF_NMI_PEND 12'h010
`define ITW_OFF_IRQ_PEND 12'h014
`define ITW_OFF_SERVICE 12'h018
`define ITW_OFF_TMR_CFG0 12'h020
`define ITW_OFF_TMR_DATA0 12'h024
`define ITW_TMR_STRIDE 12'h008

`define ITW_CTRL_KEY_EN 0
`define ITW_CTRL_EXT_RISE 1
`define ITW_CTRL_CARRIER_EN 2
`define ITW_CTRL_SLEEP 3

`define ITW_SVC_END_NMI 0
`define ITW_SVC_END_IRQ 1

`define ITW_NMI_COUNT 6
`define ITW_IRQ_COUNT 10
`define ITW_TMR_COUNT 3

`define ITW_NMI_TMR0 0
`define ITW_NMI_DIV 3
`define ITW_NMI_KEY 4
`define ITW_EXTERNAL_NONMASKABLE_REQ 5

`define ITW_IRQ_TMR0 0
`define ITW_IRQ_DIV_SHORT 3
`define ITW_IRQ_DIV_MEDIUM 4
`define ITW_IRQ_DIV_LONG 5
`define ITW_IRQ_DIV_LONGEST 6
`define ITW_IRQ_KEY 7
`define ITW_EXTERNAL_MASKABLE_REQ 8
`define ITW_IRQ_SOUND 9

`define ITW_DIV_SHORT_BITS 10
`define ITW_DIV_MEDIUM_BITS 12
`define ITW_DIV_LONG_BITS 18
`define ITW_DIV_LONGEST_BITS 21

`define ITW_SEL_GATED 3'h2
`define ITW_SEL_FREE 3'h3
`define ITW_TMR_MAX 12'hFFF

`define ITW_RST_WORD 32'h0000_0000
`define ITW_RST_SEL 3'h0
`define ITW_RST_LEVEL 4'h0

`endif

/* File: common/itw_pkg.sv */
// Types shared by the interrupt, timer and wake-up block
package itw_pkg;

    typedef struct packed {
        logic [2:0] sel;
        logic [11:0] preload;
        logic [11:0] count;
    } itw_timer_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic key_en;
        logic ext_rise;
        logic carrier_en;
        logic [7:0] wake_ref;
        logic [5:0] nmi_en;
        logic [9:0] irq_en;
        logic [5:0] nmi_pend;
        logic [9:0] irq_pend;
        logic nmi_act;
        logic [9:0] irq_isr;
        logic nmi_out;
        logic irq_out;
        logic [3:0] irq_level;
        logic sleep;
        logic [20:0] div;
        itw_timer_s [2:0] tmr;
        logic carrier;
        logic sample_tick;
        logic [7:0] wake_s1;
        logic [7:0] wake_s2;
        logic ext_s1;
        logic ext_s2;
        logic ext_d;
    } itw_state_s;

endpackage : itw_pkg

/* File: bench/itw_keypad.sv */
// Keypad and external event source standing at the block's pins
`timescale 1ns/1ps
module itw_keypad (
    input wire logic clk_sys,
    output logic [7:0] wake_port,
    output logic external_event_pin
);
    // Port pull-down holds keys low; event line idles high
    initial begin
        wake_port = 8'h00;
        external_event_pin = 1'b1;
    end
    task automatic press(input logic [7:0] keys);
        @(posedge clk_sys);
        wake_port <= keys;
    endtask : press
    task automatic ext_level(input logic lvl);
        @(posedge clk_sys);
        external_event_pin <= lvl;
    endtask : ext_level
endmodule : itw_keypad

/* File: bench/itw_asserts.sv */
// Port-level checks on the interrupt, timer and wake-up block
`timescale 1ns/1ps
module itw_asserts (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic nmi_ack,
    input wire logic nmi_out,
    input wire logic irq_out,
    input wire logic [3:0] irq_level,
    input wire logic sleep_out,
    input wire logic infrared_carrier_pin_o,
    input wire logic infrared_carrier_pin_oe,
    input wire logic sample_tick
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    carrier_oe_a: assert property (
        infrared_carrier_pin_o |-> infrared_carrier_pin_oe)
        else $error("carrier driven while pin not enabled");
    carrier_toggle_a: assert property (
        sample_tick && infrared_carrier_pin_oe && $past(infrared_carrier_pin_oe)
        |-> infrared_carrier_pin_o != $past(infrared_carrier_pin_o))
        else $error("carrier did not toggle on first timer overflow");
    level_zero_a: assert property (!irq_out |-> irq_level == 4'h0)
        else $error("irq level nonzero while idle");
    level_range_a: assert property (
        irq_out |-> irq_level >= 4'h1 && irq_level <= 4'hA)
        else $error("irq level outside 1 to 10");
    nmi_take_a: assert property (
        nmi_out && nmi_ack |-> ##2 !nmi_out ##1 !nmi_out)
        else $error("nmi reissued during its own service");
    nmi_blocks_a: assert property (
        nmi_out && nmi_ack |-> ##2 !irq_out [*2])
        else $error("maskable request during nmi service");
    sleep_wake_a: assert property (
        sleep_out && (nmi_out || irq_out) |=> !sleep_out)
        else $error("sleep held with a request raised");
endmodule : itw_asserts

bind itw_top itw_asserts u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .pready(pready), .pslverr(pslverr),
    .nmi_ack(nmi_ack), .nmi_out(nmi_out), .irq_out(irq_out),
    .irq_level(irq_level), .sleep_out(sleep_out),
    .infrared_carrier_pin_o(infrared_carrier_pin_o),
    .infrared_carrier_pin_oe(infrared_carrier_pin_oe),
    .sample_tick(sample_tick)
);

/* File: bench/tb_top.sv */
// Self-checking bench for the interrupt, timer and wake-up block
`timescale 1ns/1ps
`include "itw_defs.svh"
module tb_top;
    logic clk_sys, rst_n, psel, penable, pwrite, snd, nmi_ack, irq_ack;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, err, nmi_out, irq_out, sleep_out, ir_o, ir_oe, tick;
    logic [3:0] irq_level;
    logic [7:0] wake_port;
    logic ext_pin;
    int bad_count, num_checks, n, ticks;
    itw_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wake_port(wake_port), .external_event_pin(ext_pin),
        .sound_engine_maskable_req(snd), .nmi_ack(nmi_ack),
        .irq_ack(irq_ack), .nmi_out(nmi_out), .irq_out(irq_out),
        .irq_level(irq_level), .sleep_out(sleep_out),
        .infrared_carrier_pin_o(ir_o), .infrared_carrier_pin_oe(ir_oe),
        .sample_tick(tick));
    itw_keypad u_keys (.clk_sys(clk_sys), .wake_port(wake_port),
        .external_event_pin(ext_pin));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (tick === 1'b1) ticks <= ticks + 1;
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Request held until pready is sampled high; data taken at that edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 20);
        q = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk("pslverr", 32'h0, {31'h0, err});
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg_%h", a), e & m, q & m);
    endtask : rd
    task pulse(input int which);
        @(posedge clk_sys);
        if (which == 0) nmi_ack <= 1'b1; else if (which == 1) irq_ack <= 1'b1;
        else snd <= 1'b1;
        @(posedge clk_sys);
        nmi_ack <= 1'b0; irq_ack <= 1'b0; snd <= 1'b0;
    endtask : pulse
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        #(25 * 20000);
        bad_count++;
        tally_and_finish;
    end
    initial begin
        {rst_n, psel, penable, pwrite, snd, nmi_ack, irq_ack} = 7'h0;
        paddr = 12'h0; pwdata = 32'h0; ticks = 0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`ITW_OFF_CTRL, 32'h0, 32'hF);
        rd(`ITW_OFF_TMR_CFG0, 32'h0, 32'h7);
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        u_keys.press(8'h5A);
        wr(`ITW_OFF_WAKE_REF, 32'h5A);
        wr(`ITW_OFF_NMI_EN, 32'h10);
        wr(`ITW_OFF_CTRL, 32'h9);
        rd(`ITW_OFF_CTRL, 32'h9, 32'hF);
        u_keys.press(8'h7A);
        for (n = 0; n < 30 && nmi_out !== 1'b1; n++) @(posedge clk_sys);
        chk("sleep_out", 32'h0, {31'h0, sleep_out});
        rd(`ITW_OFF_NMI_PEND, 32'h10, 32'h37);
        pulse(0);
        u_keys.press(8'h5A);
        wr(`ITW_OFF_CTRL, 32'h4);
        wr(`ITW_OFF_NMI_PEND, 32'h3F);
        wr(`ITW_OFF_SERVICE, 32'h1);
        wr(`ITW_OFF_TMR_DATA0, 32'hFFD);
        repeat (6) @(posedge clk_sys);
        rd(`ITW_OFF_TMR_DATA0, 32'h0FFD0FFD, 32'h0FFF0FFF);
        wr(`ITW_OFF_IRQ_EN, 32'h201);
        wr(`ITW_OFF_TMR_CFG0, 32'h3);
        repeat (12) @(posedge clk_sys);
        wr(`ITW_OFF_TMR_CFG0, 32'h0);
        chk("reloads", 32'h1, {31'h0, ticks >= 2});
        chk("carrier_oe", 32'h1, {31'h0, ir_oe});
        rd(`ITW_OFF_TMR_DATA0, 32'h0FFD0000, 32'h0FFF0000);
        rd(`ITW_OFF_TMR_DATA0 + 12'h8, 32'h0, 32'h0FFF0FFF);
        rd(`ITW_OFF_IRQ_PEND, 32'h1, 32'h7);
        pulse(2);
        for (n = 0; n < 20 && irq_out !== 1'b1; n++) @(posedge clk_sys);
        chk("irq_level", 32'h1, {28'h0, irq_level});
        pulse(1);
        wr(`ITW_OFF_IRQ_PEND, 32'h1);
        repeat (4) @(posedge clk_sys);
        chk("irq_out", 32'h0, {31'h0, irq_out});
        wr(`ITW_OFF_SERVICE, 32'h2);
        for (n = 0; n < 20 && irq_out !== 1'b1; n++) @(posedge clk_sys);
        chk("irq_level", 32'hA, {28'h0, irq_level});
        pulse(1);
        wr(`ITW_OFF_IRQ_PEND, 32'h3FF);
        wr(`ITW_OFF_SERVICE, 32'h2);
        wr(`ITW_OFF_NMI_EN, 32'h20);
        u_keys.ext_level(1'b0);
        for (n = 0; n < 20 && nmi_out !== 1'b1; n++) @(posedge clk_sys);
        chk("nmi_out", 32'h1, {31'h0, nmi_out});
        pulse(0);
        pulse(2);
        repeat (6) @(posedge clk_sys);
        chk("irq_out", 32'h0, {31'h0, irq_out});
        wr(`ITW_OFF_NMI_PEND, 32'h3F);
        wr(`ITW_OFF_SERVICE, 32'h1);
        for (n = 0; n < 20 && irq_out !== 1'b1; n++) @(posedge clk_sys);
        chk("irq_level", 32'hA, {28'h0, irq_level});
        wr(`ITW_OFF_TMR_DATA0 + 12'h8, 32'h100);
        wr(`ITW_OFF_TMR_CFG0 + 12'h8, 32'h2);
        repeat (8) @(posedge clk_sys);
        rd(`ITW_OFF_TMR_DATA0 + 12'h8, 32'h100, 32'hFFF);
        u_keys.ext_level(1'b1);
        repeat (10) @(posedge clk_sys);
        apb(1'b0, `ITW_OFF_TMR_DATA0 + 12'h8, 32'h0);
        chk("gated_count", 32'h1, {31'h0, q[11:0] > 12'h100});
        // Pending flags were cleared above; a full /4096 span sets both
        repeat (4200) @(posedge clk_sys);
        rd(`ITW_OFF_IRQ_PEND, 32'h18, 32'h18);
        rd(`ITW_OFF_NMI_PEND, 32'h08, 32'h08);
        tally_and_finish;
    end
endmodule : tb_top
